//--- addr_mode_pkg.sv
package addr_mode_pkg;

  typedef enum logic [4:0] {
    m_inherent,
    m_immediate,
    m_dir_short,
    m_dir_long,
    m_idx_none,
    m_idx_short,
    m_idx_long,
    m_rel,
    m_bit_dir,
    m_bit_dir_rel,
    m_ind_short,
    m_ind_long,
    m_indidx_short,
    m_indidx_long,
    m_rel_ind,
    m_bit_ind,
    m_bit_ind_rel
  } mode_t;

  typedef enum logic [2:0] {
    s_idle,
    s_opc,
    s_b1,
    s_b2,
    s_rd,
    s_wait,
    s_done
  } state_t;

endpackage

//--- cpu_addr_consts.svh
`ifndef CPU_ADDR_CONSTS_SVH
`define CPU_ADDR_CONSTS_SVH

// Prefix byte values
`define PFX_NONE             8'h00
`define PFX_SECOND_INDEX     8'h90
`define PFX_SECOND_INDEX_IND 8'h91
`define PFX_INDIRECT         8'h92

// Page zero high address byte
`define PAGE_ZERO_HI         8'h00

// Instruction length bounds in bytes
`define LEN_MIN              3'h1
`define LEN_MAX              3'h4

// Highest addresses reached by short indexed forms (01FE) and short indirect forms (00FF)
`define SHORT_IDX_TOP        16'h01FE
`define SHORT_TOP            16'h00FF

`endif

//--- cpu_address_mode_decoder.sv
// Overview of operation
// - Long indexed: 16-bit offset from two following bytes plus index.
// - Indirect: byte after opcode addresses a page-zero pointer to operand.
// - Short indirect: one-byte pointer, operand address 00 to FF.
// - Long indirect: two-byte pointer read, full 64 Kbyte reach.
// - Indirect-indexed: unsigned sum of index and fetched pointer.
// - Short indirect-indexed reaches 00 to 1FE; long form covers 64 Kbyte.
// - Short-only operations may not use long addressing forms.
// - Relative: PC plus signed 8-bit offset for branches and calls.
// - Direct relative offset follows opcode; indirect one is read.
// - Instructions span one to four bytes: prefix, opcode, 0-2 more.
// - Prefix 90 swaps in the second index register.
// - Prefix 92 turns direct and X indexed forms into indirect ones.
// - Prefix 91 runs X indirect-indexed with the second index.
// - Short indexed: one-byte offset plus index, reaching 00 to 1FE.
// - Relative base is the address following the whole instruction.
`timescale 1ns/1ps
`include "cpu_addr_consts.svh"

module cpu_address_mode_decoder
  import addr_mode_pkg::*;
(
  input  wire logic        mclk,          // Core clock
  input  wire logic        rst_n,         // Async reset, active low
  input  wire logic        byte_valid,    // Fetched byte present
  input  wire logic [7:0]  byte_data,     // Fetched byte
  input  wire logic [15:0] byte_pc,       // Address of fetched byte
  input  wire mode_t       op_mode,       // Table mode for byte_data
  input  wire logic        op_short_only, // Opcode allows short forms only
  input  wire logic [7:0]  x_index,       // First index register
  input  wire logic [7:0]  y_index,       // Second index register
  input  wire logic        mem_rd_valid,  // Read data returned
  input  wire logic [7:0]  mem_rd_data,   // Read data
  output logic             byte_ready,    // Decoder takes a byte
  output logic             mem_rd_req,    // Pointer read request pulse
  output logic [15:0]      mem_rd_addr,   // Pointer read address
  output logic             done,          // Decode finished pulse
  output logic [15:0]      ea_addr,       // Effective operand address
  output logic [15:0]      branch_target, // Relative branch target
  output logic             target_valid,  // Target is meaningful
  output logic [7:0]       imm_data,      // Immediate operand
  output logic [2:0]       instr_len,     // Bytes in the instruction
  output mode_t            mode_out,      // Resolved addressing mode
  output logic             mode_error     // Illegal mode or prefix
);

  function automatic logic is_prefix(input logic [7:0] b);
    return b == `PFX_SECOND_INDEX || b == `PFX_SECOND_INDEX_IND ||
           b == `PFX_INDIRECT;
  endfunction

  function automatic mode_t apply_prefix(input mode_t m,
                                         input logic [7:0] p);
    mode_t r;
    r = m;
    if (p == `PFX_INDIRECT || p == `PFX_SECOND_INDEX_IND) begin
      unique case (m)
        m_dir_short:   r = m_ind_short;
        m_dir_long:    r = m_ind_long;
        m_idx_short:   r = m_indidx_short;
        m_idx_long:    r = m_indidx_long;
        m_rel:         r = m_rel_ind;
        m_bit_dir:     r = m_bit_ind;
        m_bit_dir_rel: r = m_bit_ind_rel;
        default:       r = m;
      endcase
    end
    return r;
  endfunction

  function automatic logic [1:0] operand_count(input mode_t m);
    unique case (m)
      m_inherent, m_idx_none:         return 2'h0;
      m_dir_long, m_idx_long,
      m_bit_dir_rel, m_bit_ind_rel:   return 2'h2;
      default:                        return 2'h1;
    endcase
  endfunction

  function automatic logic is_indirect(input mode_t m);
    return m inside {m_ind_short, m_ind_long, m_indidx_short,
                     m_indidx_long, m_rel_ind, m_bit_ind, m_bit_ind_rel};
  endfunction

  function automatic logic word_ptr(input mode_t m);
    return m == m_ind_long || m == m_indidx_long;
  endfunction

  function automatic logic is_long(input mode_t m);
    return m inside {m_dir_long, m_idx_long, m_ind_long, m_indidx_long};
  endfunction

  function automatic logic prefix_bad(input mode_t m, input logic [7:0] p);
    logic bad;
    bad = 1'b0;
    if (p == `PFX_SECOND_INDEX)
      bad = !(m inside {m_inherent, m_immediate, m_dir_short, m_dir_long,
                        m_idx_none, m_idx_short, m_idx_long});
    else if (p == `PFX_SECOND_INDEX_IND)
      bad = !(m inside {m_idx_short, m_idx_long});
    else if (p == `PFX_INDIRECT)
      bad = m inside {m_inherent, m_immediate, m_idx_none};
    return bad;
  endfunction

  function automatic logic [15:0] rel_add(input logic [15:0] base,
                                          input logic [7:0] off);
    return base + {{8{off[7]}}, off};
  endfunction

  state_t      state_reg, state_next;
  mode_t       mode_reg;
  logic [7:0]  pfx_reg;
  logic        use_y_reg;
  logic        err_reg;
  logic [1:0]  cnt_reg;
  logic [7:0]  b1_reg, b2_reg;
  logic [15:0] ptr_reg;
  logic        rd_second_reg;
  logic [15:0] pc_end_reg;
  logic [2:0]  len_reg;
  logic        accept;
  mode_t       dec_mode;
  logic [7:0]  idx;
  logic [8:0]  short_sum;
  logic [15:0] ea_calc;
  logic [15:0] tgt_calc;
  logic        tgt_calc_valid;

  assign accept   = byte_valid && byte_ready;
  assign dec_mode = apply_prefix(op_mode, pfx_reg);
  assign idx      = use_y_reg ? y_index : x_index;

  // Next state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      s_idle, s_opc: begin
        if (accept) begin
          if (state_reg == s_idle && is_prefix(byte_data))
            state_next = s_opc;
          else if (operand_count(dec_mode) == 2'h0)
            state_next = s_done;
          else
            state_next = s_b1;
        end
      end
      s_b1: begin
        if (accept) begin
          if (cnt_reg == 2'h2)
            state_next = s_b2;
          else if (is_indirect(mode_reg))
            state_next = s_rd;
          else
            state_next = s_done;
        end
      end
      s_b2: begin
        if (accept)
          state_next = is_indirect(mode_reg) ? s_rd : s_done;
      end
      s_rd:   state_next = s_wait;
      s_wait: begin
        if (mem_rd_valid)
          state_next = (word_ptr(mode_reg) && !rd_second_reg) ? s_rd : s_done;
      end
      s_done: state_next = s_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= s_idle;
      byte_ready <= 1'b1;
    end else begin
      state_reg  <= state_next;
      byte_ready <= state_next inside {s_idle, s_opc, s_b1, s_b2};
    end
  end

  // Prefix, opcode and operand capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pfx_reg    <= `PFX_NONE;
      mode_reg   <= m_inherent;
      use_y_reg  <= 1'b0;
      err_reg    <= 1'b0;
      cnt_reg    <= 2'h0;
      b1_reg     <= 8'h00;
      b2_reg     <= 8'h00;
      len_reg    <= 3'h0;
      pc_end_reg <= 16'h0000;
    end else if (state_reg == s_done) begin
      pfx_reg <= `PFX_NONE;
      len_reg <= 3'h0;
    end else if (accept) begin
      len_reg    <= len_reg + 3'h1;
      pc_end_reg <= byte_pc + 16'h0001;
      if (state_reg == s_idle && is_prefix(byte_data)) begin
        pfx_reg <= byte_data;
      end else if (state_reg inside {s_idle, s_opc}) begin
        mode_reg  <= dec_mode;
        cnt_reg   <= operand_count(dec_mode);
        use_y_reg <= (pfx_reg == `PFX_SECOND_INDEX) ||
                     (pfx_reg == `PFX_SECOND_INDEX_IND);
        err_reg   <= (op_short_only && is_long(dec_mode)) ||
                     prefix_bad(op_mode, pfx_reg);
      end else if (state_reg == s_b1) begin
        b1_reg <= byte_data;
      end else begin
        b2_reg <= byte_data;
      end
    end
  end

  // Pointer fetch from page zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rd_req    <= 1'b0;
      mem_rd_addr   <= 16'h0000;
      ptr_reg       <= 16'h0000;
      rd_second_reg <= 1'b0;
    end else begin
      mem_rd_req <= state_next == s_rd;
      // Pointer address byte is still on byte_data when leaving s_b1
      if (state_next == s_rd && state_reg == s_wait)
        mem_rd_addr <= {`PAGE_ZERO_HI, b1_reg + 8'h01};
      else if (state_next == s_rd && state_reg == s_b1)
        mem_rd_addr <= {`PAGE_ZERO_HI, byte_data};
      else if (state_next == s_rd)
        mem_rd_addr <= {`PAGE_ZERO_HI, b1_reg};
      if (state_reg == s_done) begin
        rd_second_reg <= 1'b0;
      end else if (state_reg == s_wait && mem_rd_valid) begin
        if (word_ptr(mode_reg) && !rd_second_reg) begin
          ptr_reg[15:8] <= mem_rd_data;
          rd_second_reg <= 1'b1;
        end else if (word_ptr(mode_reg)) begin
          ptr_reg[7:0]  <= mem_rd_data;
        end else begin
          ptr_reg       <= {8'h00, mem_rd_data};
        end
      end
    end
  end

  // Effective address and branch target
  always_comb begin
    short_sum      = 9'h000;
    ea_calc        = 16'h0000;
    tgt_calc       = pc_end_reg;
    tgt_calc_valid = 1'b0;
    unique case (mode_reg)
      m_dir_short, m_bit_dir: ea_calc = {8'h00, b1_reg};
      m_dir_long:  ea_calc = {b1_reg, b2_reg};
      m_idx_none:  ea_calc = {8'h00, idx};
      m_idx_short: begin
        short_sum = {1'b0, b1_reg} + {1'b0, idx};
        ea_calc   = {7'h00, short_sum};
      end
      m_idx_long:  ea_calc = {b1_reg, b2_reg} + {8'h00, idx};
      m_ind_short, m_bit_ind: ea_calc = ptr_reg;
      m_ind_long:  ea_calc = ptr_reg;
      m_indidx_short: begin
        short_sum = {1'b0, ptr_reg[7:0]} + {1'b0, idx};
        ea_calc   = {7'h00, short_sum};
      end
      m_indidx_long: ea_calc = ptr_reg + {8'h00, idx};
      m_rel: begin
        tgt_calc       = rel_add(pc_end_reg, b1_reg);
        tgt_calc_valid = 1'b1;
      end
      m_rel_ind: begin
        tgt_calc       = rel_add(pc_end_reg, ptr_reg[7:0]);
        tgt_calc_valid = 1'b1;
      end
      m_bit_dir_rel: begin
        ea_calc        = {8'h00, b1_reg};
        tgt_calc       = rel_add(pc_end_reg, b2_reg);
        tgt_calc_valid = 1'b1;
      end
      m_bit_ind_rel: begin
        ea_calc        = ptr_reg;
        tgt_calc       = rel_add(pc_end_reg, b2_reg);
        tgt_calc_valid = 1'b1;
      end
      m_inherent, m_immediate: ea_calc = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      done          <= 1'b0;
      ea_addr       <= 16'h0000;
      branch_target <= 16'h0000;
      target_valid  <= 1'b0;
      imm_data      <= 8'h00;
      instr_len     <= 3'h0;
      mode_out      <= m_inherent;
      mode_error    <= 1'b0;
    end else begin
      done <= state_reg == s_done;
      if (state_reg == s_done) begin
        ea_addr       <= ea_calc;
        branch_target <= tgt_calc;
        target_valid  <= tgt_calc_valid;
        imm_data      <= b1_reg;
        instr_len     <= len_reg;
        mode_out      <= mode_reg;
        mode_error    <= err_reg;
      end
    end
  end

  a_rd_single_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
    mem_rd_req |=> !mem_rd_req && !byte_ready)
    else $error("read request longer than one cycle");

  a_word_ptr_order: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_reg == s_wait && mem_rd_valid && word_ptr(mode_reg) &&
     !rd_second_reg) |=> mem_rd_req &&
     mem_rd_addr == {8'h00, b1_reg + 8'h01})
    else $error("second pointer byte not read at next address");

  a_short_ind_range: assert property (@(posedge mclk) disable iff (!rst_n)
    (done && mode_out == m_ind_short) |-> ea_addr <= `SHORT_TOP)
    else $error("short indirect address out of page zero");

  a_short_idx_range: assert property (@(posedge mclk) disable iff (!rst_n)
    (done && mode_out inside {m_idx_short, m_indidx_short}) |->
    ea_addr <= `SHORT_IDX_TOP)
    else $error("short indexed address above 1FE");

  a_long_idx_sum: assert property (@(posedge mclk) disable iff (!rst_n)
    (done && mode_out == m_idx_long) |->
    ea_addr == {$past(b1_reg), $past(b2_reg)} +
               {8'h00, $past(idx)})
    else $error("long indexed address wrong");

  a_len_bounds: assert property (@(posedge mclk) disable iff (!rst_n)
    done |-> instr_len >= `LEN_MIN && instr_len <= `LEN_MAX)
    else $error("instruction length outside one to four");

  a_rel_target: assert property (@(posedge mclk) disable iff (!rst_n)
    (done && mode_out == m_rel) |->
    branch_target == pc_end_reg + {{8{b1_reg[7]}}, b1_reg})
    else $error("relative target wrong");

  a_short_only_chk: assert property (@(posedge mclk) disable iff (!rst_n)
    (accept && state_reg inside {s_idle, s_opc} && !is_prefix(byte_data) &&
     op_short_only && is_long(dec_mode)) |=> err_reg)
    else $error("long form accepted for short-only operation");

  a_prefix_y_sel: assert property (@(posedge mclk) disable iff (!rst_n)
    (accept && state_reg == s_opc && pfx_reg == `PFX_SECOND_INDEX_IND)
    |=> use_y_reg)
    else $error("second index not selected after prefix");

endmodule

//--- mem_model.sv
`timescale 1ns/1ps

module mem_model (
  input  wire logic        mclk,         // Core clock
  input  wire logic        rst_n,        // Async reset, active low
  input  wire logic        mem_rd_req,   // Read request pulse
  input  wire logic [15:0] mem_rd_addr,  // Read address
  output logic             mem_rd_valid, // Read data returned
  output logic [7:0]       mem_rd_data   // Read data
);
  logic        busy_reg;
  logic [1:0]  wait_reg;
  logic [1:0]  lat_reg;
  logic [15:0] addr_reg;

  // Latency rotates 1..4 cycles; data toggles while not valid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg     <= 1'b0;
      wait_reg     <= 2'h0;
      lat_reg      <= 2'h0;
      addr_reg     <= 16'h0000;
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= 8'h00;
    end else begin
      mem_rd_valid <= 1'b0;
      mem_rd_data  <= ~mem_rd_data;
      if (mem_rd_req) begin
        busy_reg <= 1'b1;
        addr_reg <= mem_rd_addr;
        wait_reg <= lat_reg;
        lat_reg  <= lat_reg + 2'h1;
      end else if (busy_reg) begin
        if (wait_reg == 2'h0) begin
          mem_rd_valid <= 1'b1;
          mem_rd_data  <= addr_reg[7:0] * 8'h07 + 8'h03;
          busy_reg     <= 1'b0;
        end else begin
          wait_reg <= wait_reg - 2'h1;
        end
      end
    end
  end
endmodule

//--- tb_cpu_address_mode_decoder.sv
`timescale 1ns/1ps

module tb_cpu_address_mode_decoder
  import addr_mode_pkg::*;
;
  logic        mclk, rst_n, byte_valid, op_short_only;
  logic [7:0]  byte_data, x_index, y_index, mem_rd_data, imm_data;
  logic [15:0] byte_pc, mem_rd_addr, ea_addr, branch_target;
  logic        mem_rd_valid, byte_ready, mem_rd_req, done;
  logic        target_valid, mode_error;
  logic [2:0]  instr_len;
  mode_t       op_mode, mode_out;
  int          num_errors, cmp_count;
  logic [31:0] seed;
  logic [7:0]  pfx_tab [24];
  mode_t       mode_tab [24];

  cpu_address_mode_decoder uut (
    .mclk(mclk), .rst_n(rst_n), .byte_valid(byte_valid),
    .byte_data(byte_data), .byte_pc(byte_pc), .op_mode(op_mode),
    .op_short_only(op_short_only), .x_index(x_index), .y_index(y_index),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .byte_ready(byte_ready), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .done(done), .ea_addr(ea_addr),
    .branch_target(branch_target), .target_valid(target_valid),
    .imm_data(imm_data), .instr_len(instr_len), .mode_out(mode_out),
    .mode_error(mode_error));

  mem_model mem (
    .mclk(mclk), .rst_n(rst_n), .mem_rd_req(mem_rd_req),
    .mem_rd_addr(mem_rd_addr), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] mb(input logic [7:0] a);
    return a * 8'h07 + 8'h03;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic send(input logic [7:0] d, input logic [15:0] a,
                      input mode_t m);
    int n;
    @(negedge mclk);
    byte_valid = 1'b1;
    byte_data  = d;
    byte_pc    = a;
    op_mode    = m;
    n = 0;
    while (byte_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n == 50)
      num_errors++;
    @(posedge mclk);
  endtask

  task automatic run_instr(input int k);
    logic [7:0]  pf, b1, b2, p0, p1, ix, o;
    logic [15:0] pc, hp, ea, tg;
    mode_t       md, rm;
    int          nb, n;
    logic        ind, er, tv;
    pf = pfx_tab[k];
    md = mode_tab[k];
    op_short_only = (k == 15 || k == 22);
    seed = lfsr(seed);
    b1 = seed[7:0];
    b2 = seed[15:8];
    x_index = seed[23:16];
    y_index = seed[31:24];
    if (seed[2]) begin
      b1 = 8'hFF;
      x_index = 8'hFF;
      y_index = 8'hFF;
    end
    seed = lfsr(seed);
    pc = seed[15:0];
    hp = (pf != 8'h00) ? 16'h0001 : 16'h0000;
    ix = (pf == 8'h90 || pf == 8'h91) ? y_index : x_index;
    p0 = mb(b1);
    p1 = mb(b1 + 8'h01);
    rm = md;
    ea = 16'h0000;
    nb = 1;
    ind = (pf == 8'h92 || pf == 8'h91);
    o = b1;
    case (md)
      m_inherent: nb = 0;
      m_idx_none: begin
        nb = 0;
        ea = {8'h00, ix};
      end
      m_idx_short: begin
        rm = ind ? m_indidx_short : m_idx_short;
        ea = ind ? p0 + ix : b1 + ix;
      end
      m_idx_long: begin
        rm = ind ? m_indidx_long : m_idx_long;
        nb = ind ? 1 : 2;
        ea = (ind ? {p0, p1} : {b1, b2}) + ix;
      end
      m_dir_short: begin
        rm = ind ? m_ind_short : m_dir_short;
        ea = {8'h00, ind ? p0 : b1};
      end
      m_dir_long: begin
        rm = ind ? m_ind_long : m_dir_long;
        nb = ind ? 1 : 2;
        ea = ind ? {p0, p1} : {b1, b2};
      end
      m_bit_dir: begin
        rm = ind ? m_bit_ind : m_bit_dir;
        ea = {8'h00, ind ? p0 : b1};
      end
      m_bit_dir_rel: begin
        rm = ind ? m_bit_ind_rel : m_bit_dir_rel;
        nb = 2;
        ea = {8'h00, ind ? p0 : b1};
        o = b2;
      end
      m_rel: begin
        rm = ind ? m_rel_ind : m_rel;
        o = ind ? p0 : b1;
      end
      default: ;
    endcase
    er = (k == 15 || k == 23);
    tv = (md == m_rel || md == m_bit_dir_rel);
    tg = pc + hp + 16'(nb) + 16'h0001 + {{8{o[7]}}, o};
    if (pf != 8'h00) send(pf, pc, m_inherent);
    send(8'hA6, pc + hp, md);
    for (int i = 0; i < nb; i++)
      send(i == 0 ? b1 : b2, pc + hp + 16'(i + 1), m_inherent);
    @(negedge mclk);
    byte_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge mclk);
      n++;
    end
    check({15'h0000, done}, 16'h0001);
    check({15'h0000, mode_error}, {15'h0000, er});
    check(ea_addr, ea);
    check({13'h0000, instr_len}, 16'(hp + 16'(nb) + 16'h0001));
    check({11'h000, mode_out}, {11'h000, rm});
    check({15'h0000, target_valid}, {15'h0000, tv});
    if (tv) check(branch_target, tg);
    if (md == m_immediate) check({8'h00, imm_data}, {8'h00, b1});
    $display("test %0d ended", k);
  endtask

  initial begin
    #(50 * 20000);
    num_errors++;
    give_verdict();
  end

  initial begin
    num_errors = 0;
    cmp_count = 0;
    seed = 32'hD45A;
    rst_n = 1'b0;
    byte_valid = 1'b0;
    byte_data = 8'h00;
    byte_pc = 16'h0000;
    op_mode = m_inherent;
    op_short_only = 1'b0;
    x_index = 8'h00;
    y_index = 8'h00;
    pfx_tab = '{8'h00, 8'h00, 8'h00, 8'h90, 8'h00, 8'h90, 8'h92, 8'h92,
                8'h92, 8'h91, 8'h92, 8'h91, 8'h00, 8'h92, 8'h92, 8'h00,
                8'h00, 8'h90, 8'h00, 8'h00, 8'h00, 8'h92, 8'h00, 8'h90};
    mode_tab = '{m_inherent, m_immediate, m_idx_short, m_idx_short,
                 m_idx_long, m_idx_long, m_dir_short, m_dir_long,
                 m_idx_short, m_idx_short, m_idx_long, m_idx_long,
                 m_rel, m_rel, m_bit_dir, m_idx_long,
                 m_idx_none, m_idx_none, m_dir_short, m_dir_long,
                 m_bit_dir_rel, m_bit_dir_rel, m_bit_dir, m_rel};
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    for (int k = 0; k < 24; k++) run_instr(k);
    for (int j = 0; j < 200; j++) begin
      seed = lfsr(seed);
      run_instr(int'(seed[7:0]) % 24);
    end
    give_verdict();
  end
endmodule
